// *** verilog/flash_cmd_decoder.sv ***
// Control, status, identity and address-mode command decoder of a serial flash
`default_nettype none
module flash_cmd_decoder
   import flash_cmd_pkg::*;
#(
   // Identity values, arbitrary
   parameter logic [7:0] maker_code = 8'ha5,
   parameter logic [7:0] memory_type = 8'h3c,
   parameter logic [7:0] memory_capacity = 8'h21,
   parameter logic [7:0] part_code = 8'h42
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] dq_in,
   output logic [3:0] dq_out,
   output logic [3:0] dq_oe,
   // Continuation mode request from the array read logic
   input wire logic cont_mode_set,
   // Parameter table lookup
   output logic [23:0] param_addr,
   input wire logic [7:0] param_data,
   // Device state
   output logic quad_mode,
   output logic cont_mode,
   output logic addr4_mode,
   output logic sleeping,
   output logic [7:0] ext_addr,
   output logic [7:0] status1,
   output logic [7:0] status2,
   output logic [7:0] status3,
   output logic quad_lane_enable,
   output logic soft_reset_done
);
   import flash_cmd_pkg::*;

   spi_link_if link ();

   logic [7:0] opcode;
   logic [7:0] cnt;
   logic [7:0] data1;
   logic [7:0] data2;
   logic [7:0] data3;
   logic [7:0] nv1;
   logic [7:0] nv2;
   logic [7:0] nv3;
   logic reset_armed;
   logic volatile_armed;
   logic reply_pend;
   lane_e lane;
   logic byte_done;
   logic [7:0] rx_byte;
   logic whole_byte;
   logic reply_valid;
   logic [7:0] reply_byte;

   // Pin synchronisers and edge finding
   spi_pin_front front (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .sclk(sclk),
      .cs_n(cs_n),
      .dq_in(dq_in),
      .link(link)
   );

   // Byte shifting in both directions
   spi_byte_shift shifter (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .link(link),
      .lane(lane),
      .byte_done(byte_done),
      .rx_byte(rx_byte),
      .whole_byte(whole_byte),
      .load_valid(reply_valid),
      .load_byte(reply_byte),
      .dq_out(dq_out),
      .dq_oe(dq_oe)
   );

   // Opcode of the frame, including the byte just arrived
   wire [7:0] cur_op = (cnt == 8'h00) ? rx_byte : opcode;
   wire [7:0] next_cnt = (cnt == 8'hff) ? cnt : cnt + 8'h01;
   wire frame_end = link.cs_rise && (cnt != 8'h00);
   wire do_write = frame_end && whole_byte && !sleeping;

   // Phase lanes after the opcode: quad frames stay quad
   wire lane_e body_lane = quad_mode ? lane_four :
                           (rx_byte == maker_part_dual_cmd) ? lane_two :
                           (rx_byte == maker_part_quad_cmd) ? lane_four : lane_one;
   wire lane_e idle_lane = quad_mode ? lane_four : lane_one;

   // Reply selection by opcode and byte position
   wire op_sr1 = (opcode == status1_read_cmd);
   wire op_sr2 = (opcode == status2_read_cmd) || (opcode == status2_read_alt_cmd);
   wire op_sr3 = (opcode == status3_read_cmd) || (opcode == status3_read_alt_cmd);
   wire op_ext = (opcode == ext_addr_read_cmd);
   wire op_wake = (opcode == wake_and_part_code_cmd);
   wire op_mp = (opcode == maker_part_read_cmd) || (opcode == maker_part_dual_cmd) ||
                (opcode == maker_part_quad_cmd);
   wire op_id = (opcode == three_byte_identity_read_cmd);
   wire op_param = (opcode == param_read_cmd);
   wire mp_part = cnt[0] ^ data3[0];
   wire [7:0] id_byte = (cnt == 8'h01) ? maker_code :
                        (cnt == 8'h02) ? memory_type : memory_capacity;
   wire reply_ok = !sleeping && (op_sr1 || op_sr2 || op_sr3 || op_ext) ||
                   op_wake && (cnt >= part_code_first_byte) ||
                   !sleeping && op_mp && (cnt >= maker_part_first_byte) ||
                   !sleeping && op_id && (cnt <= identity_last_byte) ||
                   !sleeping && op_param && (cnt >= param_first_byte);
   assign reply_byte = op_sr1 ? status1 :
                           op_sr2 ? status2 :
                           op_sr3 ? status3 :
                           op_ext ? ext_addr :
                           op_wake ? part_code :
                           op_mp ? (mp_part ? part_code : maker_code) :
                           op_id ? id_byte :
                           param_data;
   assign reply_valid = reply_pend && reply_ok;

   // Status write results, WEL and BUSY are not writable
   wire [7:0] wr_sr1 = (data1 & sr1_write_mask) | (status1 & ~sr1_write_mask);
   wire nv_write = !volatile_armed;
   wire sr_write_ok = volatile_armed || status1[wel_bit];
   wire sw_reset = do_write && (opcode == soft_reset_cmd) && reset_armed;

   // Frame bookkeeping: opcode, byte count, captured data, lanes
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         opcode <= 8'h00;
         cnt <= 8'h00;
         data1 <= 8'h00;
         data2 <= 8'h00;
         data3 <= 8'h00;
         lane <= lane_one;
         reply_pend <= 1'b0;
      end else if (!link.cs_active) begin
         cnt <= 8'h00;
         reply_pend <= 1'b0;
         lane <= idle_lane;
      end else begin
         reply_pend <= byte_done; // Reply in the cycle after byte_done, once the count has moved
         if (byte_done) begin
            cnt <= next_cnt;
            if (cnt == 8'h00) begin
               opcode <= rx_byte;
               lane <= body_lane;
            end
            if (cnt == 8'h01) data1 <= rx_byte;
            if (cnt == 8'h02) data2 <= rx_byte;
            if (cnt == selector_byte) data3 <= rx_byte;
         end
      end
   end

   // Parameter address: three bytes MSB first, then one step per byte out
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         param_addr <= 24'h000000;
      end else if (byte_done && cur_op == param_read_cmd && cnt != 8'h00) begin
         if (cnt < 8'h04) begin
            param_addr <= {param_addr[15:0], rx_byte};
         end else if (cnt >= param_first_byte) begin
            param_addr <= param_addr + 24'h000001;
         end
      end
   end

   // Two-command sequences, judged at each instruction end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reset_armed <= 1'b0;
         volatile_armed <= 1'b0;
      end else if (frame_end) begin
         reset_armed <= do_write && (opcode == reset_arm_cmd);
         volatile_armed <= do_write && (opcode == volatile_arm_cmd);
      end
   end

   // Modes; a software reset drops every mode
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         quad_mode <= 1'b0;
         cont_mode <= 1'b0;
         addr4_mode <= 1'b0;
         sleeping <= 1'b0;
         ext_addr <= ext_addr_reset;
         soft_reset_done <= 1'b0;
      end else begin
         soft_reset_done <= sw_reset;
         if (cont_mode_set) cont_mode <= 1'b1;
         // Wake as soon as the opcode is seen, before the dummies
         if (byte_done && cnt == 8'h00 && rx_byte == wake_and_part_code_cmd) begin
            sleeping <= 1'b0;
         end
         if (sw_reset) begin
            quad_mode <= 1'b0;
            cont_mode <= 1'b0;
            addr4_mode <= 1'b0;
            sleeping <= 1'b0;
            ext_addr <= ext_addr_reset;
         end else if (do_write) begin
            case (opcode)
               enter_full_quad_cmd: quad_mode <= 1'b1;
               leave_full_quad_cmd: begin
                  quad_mode <= 1'b0;
                  cont_mode <= 1'b0;
               end
               sleep_cmd: sleeping <= 1'b1;
               addr4_enter_cmd: addr4_mode <= 1'b1;
               addr4_exit_cmd: addr4_mode <= 1'b0;
               ext_addr_write_cmd: if (cnt == 8'h02) ext_addr <= data1;
               default: ;
            endcase
         end
      end
   end

   // Status registers: working copy and the copy that survives a soft reset
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         status1 <= sr1_reset;
         status2 <= sr2_reset;
         status3 <= sr3_reset;
         nv1 <= sr1_reset;
         nv2 <= sr2_reset;
         nv3 <= sr3_reset;
      end else if (sw_reset) begin
         status1 <= nv1;
         status2 <= nv2;
         status3 <= nv3;
      end else if (do_write) begin
         case (opcode)
            write_latch_set_cmd: status1[wel_bit] <= 1'b1;
            write_latch_clear_cmd: status1[wel_bit] <= 1'b0;
            status_write_cmd: if (sr_write_ok && cnt >= 8'h02) begin
               // As many registers as bytes were supplied
               status1 <= wr_sr1;
               if (cnt >= 8'h03) status2 <= data2;
               if (cnt >= 8'h04) status3 <= data3;
               if (nv_write) begin
                  status1[wel_bit] <= 1'b0;
                  nv1 <= wr_sr1 & ~(8'h01 << wel_bit);
                  if (cnt >= 8'h03) nv2 <= data2;
                  if (cnt >= 8'h04) nv3 <= data3;
               end
            end
            status2_write_cmd: if (sr_write_ok && cnt == 8'h02) begin
               status2 <= data1;
               if (nv_write) begin
                  nv2 <= data1;
                  status1[wel_bit] <= 1'b0;
               end
            end
            status3_write_cmd, status3_write_alt_cmd: if (sr_write_ok && cnt == 8'h02) begin
               status3 <= data1;
               if (nv_write) begin
                  nv3 <= data1;
                  status1[wel_bit] <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // Quad lane enable follows its status field
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         quad_lane_enable <= sr2_reset[quad_lane_enable_bit];
      end else begin
         quad_lane_enable <= status2[quad_lane_enable_bit];
      end
   end
endmodule // flash_cmd_decoder
`default_nettype wire

// *** verilog/flash_cmd_pkg.sv ***
// Opcodes, lane widths, field positions and reset values for the command decoder
`default_nettype none
package flash_cmd_pkg;
   // Opcodes handled by the decoder
   localparam logic [7:0] reset_arm_cmd = 8'h66;
   localparam logic [7:0] soft_reset_cmd = 8'h99;
   localparam logic [7:0] enter_full_quad_cmd = 8'h38;
   localparam logic [7:0] leave_full_quad_cmd = 8'hff;
   localparam logic [7:0] write_latch_set_cmd = 8'h06;
   localparam logic [7:0] volatile_arm_cmd = 8'h50;
   localparam logic [7:0] write_latch_clear_cmd = 8'h04;
   localparam logic [7:0] status1_read_cmd = 8'h05;
   localparam logic [7:0] status2_read_cmd = 8'h09;
   localparam logic [7:0] status2_read_alt_cmd = 8'h35;
   localparam logic [7:0] status3_read_cmd = 8'h95;
   localparam logic [7:0] status3_read_alt_cmd = 8'h15;
   localparam logic [7:0] status_write_cmd = 8'h01;
   localparam logic [7:0] status2_write_cmd = 8'h31;
   localparam logic [7:0] status3_write_cmd = 8'hc0;
   localparam logic [7:0] status3_write_alt_cmd = 8'h11;
   localparam logic [7:0] sleep_cmd = 8'hb9;
   localparam logic [7:0] wake_and_part_code_cmd = 8'hab;
   localparam logic [7:0] maker_part_read_cmd = 8'h90;
   localparam logic [7:0] maker_part_dual_cmd = 8'h92;
   localparam logic [7:0] maker_part_quad_cmd = 8'h94;
   localparam logic [7:0] three_byte_identity_read_cmd = 8'h9f;
   localparam logic [7:0] param_read_cmd = 8'h5a;
   localparam logic [7:0] ext_addr_write_cmd = 8'hc5;
   localparam logic [7:0] ext_addr_read_cmd = 8'hc8;
   localparam logic [7:0] addr4_enter_cmd = 8'hb7;
   localparam logic [7:0] addr4_exit_cmd = 8'he9;
   // Byte positions in a frame, opcode is byte 0
   localparam logic [7:0] part_code_first_byte = 8'h04;
   localparam logic [7:0] selector_byte = 8'h03;
   localparam logic [7:0] maker_part_first_byte = 8'h04;
   localparam logic [7:0] param_first_byte = 8'h05;
   localparam logic [7:0] identity_last_byte = 8'h03;
   localparam logic [3:0] bits_per_byte = 4'h8;
   // Status field positions and reset values
   localparam int busy_bit = 0;
   localparam int wel_bit = 1;
   localparam int quad_lane_enable_bit = 1;
   localparam logic [7:0] sr1_write_mask = 8'hfc;
   localparam logic [7:0] sr1_reset = 8'h00;
   localparam logic [7:0] sr2_reset = 8'h00;
   localparam logic [7:0] sr3_reset = 8'h00;
   localparam logic [7:0] ext_addr_reset = 8'h00;
   // Lanes carrying one phase of a frame
   typedef enum logic [1:0] {lane_one, lane_two, lane_four} lane_e;
endpackage
`default_nettype wire

// *** verilog/spi_link_if.sv ***
// Synchronised link events shared by the pin front end and its users
`default_nettype none
interface spi_link_if;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_active;
   logic cs_rise;
   logic [3:0] dq;
   modport front (output sclk_rise, output sclk_fall, output cs_active, output cs_rise,
      output dq);
   modport user (input sclk_rise, input sclk_fall, input cs_active, input cs_rise, input dq);
endinterface
`default_nettype wire

// *** verilog/spi_pin_front.sv ***
// Two-stage synchronisers and edge finding for the serial pins
`default_nettype none
module spi_pin_front (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Raw pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] dq_in,
   // Events
   spi_link_if.front link
);
   logic [5:0] meta;
   logic [5:0] sync;
   logic sclk_old;
   logic cs_old;

   // Only the second stage is looked at by anything
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta <= 6'h3f;
         sync <= 6'h3f;
         sclk_old <= 1'b1;
         cs_old <= 1'b1;
      end else begin
         meta <= {dq_in, cs_n, sclk};
         sync <= meta;
         sclk_old <= sync[0];
         cs_old <= sync[1];
      end
   end

   // Edges of the sampled link clock and select
   assign link.sclk_rise = sync[0] & ~sclk_old;
   assign link.sclk_fall = ~sync[0] & sclk_old;
   assign link.cs_active = ~sync[1];
   assign link.cs_rise = sync[1] & ~cs_old;
   assign link.dq = sync[5:2];
endmodule // spi_pin_front
`default_nettype wire

// *** verilog/spi_byte_shift.sv ***
// Byte assembly on rising edges and byte output on falling edges, 1/2/4 lanes
`default_nettype none
module spi_byte_shift
   import flash_cmd_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Link events
   spi_link_if.user link,
   // Lane width of the current phase
   input wire flash_cmd_pkg::lane_e lane,
   // Received bytes
   output logic byte_done,
   output logic [7:0] rx_byte,
   output logic whole_byte,
   // Byte to send next
   input wire logic load_valid,
   input wire logic [7:0] load_byte,
   // Pin drive
   output logic [3:0] dq_out,
   output logic [3:0] dq_oe
);
   import flash_cmd_pkg::*;

   logic [3:0] bit_cnt;
   logic [7:0] rx;
   logic [7:0] tx;
   logic [7:0] hold;
   logic hold_full;
   logic byte_start;

   // Bits moved per edge for a lane width
   function automatic logic [3:0] lane_bits(input lane_e l);
      case (l)
         lane_two: lane_bits = 4'h2;
         lane_four: lane_bits = 4'h4;
         default: lane_bits = 4'h1;
      endcase
   endfunction

   // Placement of the top bits of a byte on the pins, MSB first
   function automatic logic [3:0] place(input lane_e l, input logic [7:0] b);
      case (l)
         lane_two: place = {2'b00, b[7:6]};
         lane_four: place = b[7:4];
         default: place = {2'b00, b[7], 1'b0};
      endcase
   endfunction

   wire [3:0] step = lane_bits(lane);
   wire [3:0] next_cnt = bit_cnt + step;
   wire [7:0] next_rx = (lane == lane_four) ? {rx[3:0], link.dq} :
                        (lane == lane_two) ? {rx[5:0], link.dq[1:0]} :
                        {rx[6:0], link.dq[0]};
   wire [7:0] next_tx = tx << step;
   wire [3:0] lane_mask = (lane == lane_four) ? 4'hf : (lane == lane_two) ? 4'h3 : 4'h2;

   assign whole_byte = (bit_cnt == 4'h0);

   // Input side, MSB first on every rising link edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt <= 4'h0;
         rx <= 8'h00;
         rx_byte <= 8'h00;
         byte_done <= 1'b0;
      end else begin
         byte_done <= 1'b0;
         if (!link.cs_active) begin
            bit_cnt <= 4'h0;
         end else if (link.sclk_rise) begin
            rx <= next_rx;
            if (next_cnt == bits_per_byte) begin
               bit_cnt <= 4'h0;
               rx_byte <= next_rx;
               byte_done <= 1'b1;
            end else begin
               bit_cnt <= next_cnt;
            end
         end
      end
   end

   // Output side, a new byte starts on the first falling edge after a byte in
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx <= 8'h00;
         hold <= 8'h00;
         hold_full <= 1'b0;
         byte_start <= 1'b0;
         dq_out <= 4'h0;
         dq_oe <= 4'h0;
      end else if (!link.cs_active) begin
         hold_full <= 1'b0;
         byte_start <= 1'b0;
         dq_oe <= 4'h0;
      end else begin
         if (load_valid) begin
            hold <= load_byte;
            hold_full <= 1'b1;
         end
         if (byte_done) begin
            byte_start <= 1'b1;
         end else if (link.sclk_fall) begin
            byte_start <= 1'b0;
            if (byte_start && hold_full && !load_valid) begin
               tx <= hold;
               hold_full <= 1'b0;
               dq_out <= place(lane, hold);
               dq_oe <= lane_mask;
            end else if (byte_start) begin
               dq_oe <= 4'h0;
            end else begin
               tx <= next_tx;
               dq_out <= place(lane, next_tx);
            end
         end
      end
   end
endmodule // spi_byte_shift
`default_nettype wire

// *** sim/spi_host_model.sv ***
// Behavioural SPI host that frames instructions for the command decoder
`default_nettype none
module spi_host_model (
   // Serial pins towards the device
   output logic sclk,
   output logic cs_n,
   output logic [3:0] host_dq,
   // Resolved data lines
   input wire logic [3:0] dq_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // Mode 0 idle: clock low, deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      host_dq = 4'h5;
   end
   // Bit groups on w lanes, MSB first, reply sampled just before the rise
   task automatic shift(input logic [7:0] tx, input int w, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 8 - w; i >= 8 - nb; i -= w) begin
         for (int j = 0; j < 4; j++) begin
            host_dq[j] = (j < w) ? tx[i + j] : ~host_dq[j];
         end
         #400;
         for (int j = 0; j < w; j++) begin
            rx[i + j] = (w == 1) ? dq_line[1] : dq_line[j];
         end
         sclk = 1'b1;
         #400;
         sclk = 1'b0;
      end
   endtask
   // Opcode, body bytes, stray bits, then reply bytes; cs_n high between frames
   task automatic frame(input logic [31:0] tx, input int n_tx, input int w_op,
      input int w_body, input int n_rx, input int extra, output logic [31:0] rx);
      logic [7:0] b;
      logic [31:0] t;
      t = tx;
      rx = 32'h0;
      cs_n = 1'b0;
      #400;
      for (int k = 0; k < n_tx; k++) begin
         shift(t[31:24], (k == 0) ? w_op : w_body, 8, b);
         t = t << 8;
      end
      if (extra > 0) begin
         shift(8'hff, 1, extra, b);
      end
      for (int k = 0; k < n_rx; k++) begin
         shift(t[31:24], (n_tx > 1) ? w_body : w_op, 8, b);
         rx = {rx[23:0], b};
      end
      #400;
      cs_n = 1'b1;
      host_dq = ~host_dq; // Released lines show no stale value
      #1600;
   endtask
endmodule // spi_host_model
`default_nettype wire

// *** sim/flash_cmd_decoder_assertions.sv ***
// Concurrent checks on the command decoder's top-level ports
`default_nettype none
module flash_cmd_decoder_assertions (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Inputs watched
   input wire logic cs_n,
   input wire logic cont_mode_set,
   // Outputs watched
   input wire logic [3:0] dq_oe,
   input wire logic quad_mode,
   input wire logic cont_mode,
   input wire logic addr4_mode,
   input wire logic [7:0] ext_addr,
   input wire logic [7:0] status1,
   input wire logic soft_reset_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // Output drive follows selection, sync latency allowed, and uses only legal lane patterns
   AST_OE_DROP: assert property ($rose(cs_n) |-> ##[1:4] dq_oe == 4'h0)
      else $error("output enable held after deselect");
   AST_OE_IDLE: assert property (cs_n [*5] |-> dq_oe == 4'h0)
      else $error("output driven while deselected");
   AST_OE_LANES: assert property (dq_oe != 4'h0 |-> dq_oe inside {4'h2, 4'h3, 4'hf})
      else $error("illegal lane enable pattern");
   AST_QUAD_LANES: assert property (quad_mode && dq_oe != 4'h0 |-> dq_oe == 4'hf)
      else $error("reply not on four lanes in quad mode");
   // Software reset effects
   AST_RESET_STATE: assert property (soft_reset_done |-> ##[0:1] (!addr4_mode
      && !quad_mode && ext_addr == 8'h00 && status1[1:0] == 2'b00))
      else $error("state not cleared by software reset");
   AST_RESET_PULSE: assert property (soft_reset_done |=> !soft_reset_done [*2])
      else $error("reset done not a single pulse");
   // Writes take effect only once the frame has ended; a continuation request while deselected takes effect in the next cycle
   AST_ADDR4_AT_END: assert property ($changed(addr4_mode) |-> cs_n)
      else $error("address mode changed inside a frame");
   AST_EXT_STABLE: assert property (!cs_n [*4] |=> $stable(ext_addr))
      else $error("extended address changed inside a frame");
   AST_STATUS_AT_END: assert property ($changed(status1) |-> cs_n)
      else $error("status changed inside a frame");
   AST_CONT_SET: assert property (cont_mode_set && cs_n && $past(cs_n, 4) |=> cont_mode)
      else $error("continuation request lost");
   // Main scenarios reached
   COV_RESET: cover property (soft_reset_done);
   COV_QUAD_REPLY: cover property (dq_oe == 4'hf);
   COV_QUAD_EXIT: cover property ($fell(quad_mode));
   COV_CONT_EXIT: cover property ($fell(cont_mode));
endmodule // flash_cmd_decoder_assertions
`default_nettype wire

// *** sim/test_flash_cmd_decoder.sv ***
// Self-checking bench for the command decoder, driven by the SPI host model
`default_nettype none
module test_flash_cmd_decoder;
   import flash_cmd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, nrst, sclk, cs_n, cont_mode_set, quad_mode, cont_mode, addr4_mode, sleeping;
   logic quad_lane_enable, soft_reset_done;
   logic [3:0] dq_in, dq_out, dq_oe, host_dq;
   logic [23:0] param_addr;
   logic [7:0] param_data, ext_addr, status1, status2, status3;
   logic [31:0] rx;
   int n_fail = 0;
   int n_compared = 0;
   int n_resets = 0;
   logic [7:0] rd_op [4] = '{8'h09, 8'h35, 8'h95, 8'h15};
   logic [7:0] id_op [3] = '{8'h90, 8'h92, 8'h94};
   // Wire level: device wins where it drives
   assign dq_in = (dq_oe & dq_out) | (~dq_oe & host_dq);
   // Parameter table stand-in
   assign param_data = param_addr[7:0] ^ 8'hc3;
   flash_cmd_decoder flash_cmd_decoder_inst (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk),
      .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .cont_mode_set(cont_mode_set), .param_addr(param_addr), .param_data(param_data),
      .quad_mode(quad_mode), .cont_mode(cont_mode), .addr4_mode(addr4_mode),
      .sleeping(sleeping), .ext_addr(ext_addr), .status1(status1), .status2(status2),
      .status3(status3), .quad_lane_enable(quad_lane_enable),
      .soft_reset_done(soft_reset_done));
   spi_host_model spi_host_model_inst (.sclk(sclk), .cs_n(cs_n), .host_dq(host_dq),
      .dq_line(dq_in));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Count reset pulses; a missed pulse is caught by the count
   always @(posedge ref_clk) begin
      if (soft_reset_done === 1'b1) n_resets++;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Single-lane instruction of n bytes with nrx reply bytes
   task automatic cmd(input logic [31:0] tx, input int n, input int nrx = 0);
      spi_host_model_inst.frame(tx, n, 1, 1, nrx, 0, rx);
   endtask
   task automatic stop_test;
      if (n_fail == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hang guard, several times the expected run
   initial begin
      #3000000;
      n_fail++;
      stop_test();
   end
   initial begin
      nrst = 1'b0;
      cont_mode_set = 1'b0;
      repeat (5) @(posedge ref_clk);
      #10 nrst = 1'b1;
      repeat (4) @(posedge ref_clk);
      #10;
      check("reset", {addr4_mode, status1, status2, status3}, 32'h0);
      cmd(32'h06000000, 1);
      check("latch set", status1, 8'h02);
      cmd(32'h05000000, 1, 2);
      check("sr1 read", rx, 32'h0202);
      cmd(32'h04000000, 1);
      check("latch clear", status1, 8'h00);
      cmd(32'h06000000, 1);
      cmd(32'h013c0260, 4);
      check("sr write", {status1, status2, status3, 7'h0, quad_lane_enable}, 32'h3c026001);
      foreach (rd_op[k]) begin
         cmd({rd_op[k], 24'h0}, 1, 2);
         check("sr2 sr3 read", rx, (k < 2) ? 32'h0202 : 32'h6060);
      end
      cmd(32'h06000000, 1);
      cmd(32'h31000000, 2);
      check("sr2 only", {status1, status2}, 16'h3c00);
      cmd(32'h06000000, 1);
      cmd(32'hc0110000, 2);
      check("sr3 only", status3, 8'h11);
      cmd(32'h06000000, 1);
      cmd(32'h11220000, 2);
      check("sr3 alt", status3, 8'h22);
      cmd(32'h06000000, 1);
      spi_host_model_inst.frame(32'h31ff0000, 2, 1, 1, 0, 3, rx);
      check("short write", status2, 8'h00);
      cmd(32'h04000000, 1);
      cmd(32'h01400000, 2);
      check("no latch", status1, 8'h3c);
      cmd(32'h50000000, 1);
      cmd(32'h01800000, 2);
      check("volatile", status1, 8'h80);
      cmd(32'hc55a0000, 2);
      cmd(32'hc8000000, 1, 1);
      check("ext addr", {ext_addr, rx[7:0]}, 16'h5a5a);
      cmd(32'hb7000000, 1);
      check("addr4 on", addr4_mode, 1'b1);
      cmd(32'h66000000, 1);
      cmd(32'h06000000, 1);
      cmd(32'h99000000, 1);
      check("disarmed", {n_resets[7:0], status1}, 16'h0082);
      cmd(32'h66000000, 1);
      cmd(32'h99000000, 1);
      check("reset", {n_resets[7:0], status1, ext_addr, 7'h0, addr4_mode}, 32'h013c0000);
      cmd(32'hb7000000, 1);
      cmd(32'he9000000, 1);
      check("addr4 off", addr4_mode, 1'b0);
      cmd(32'hb9000000, 1);
      check("asleep", sleeping, 1'b1);
      cmd(32'hab000000, 4, 2);
      check("wake id", {sleeping, rx[15:0]}, {1'b0, 16'h4242});
      for (int k = 0; k < 6; k++) begin
         spi_host_model_inst.frame({id_op[k / 2], 16'h0, 8'(k % 2)}, 4, 1, 1 << (k / 2), 2, 0, rx);
         check("maker part", rx[15:0], (k % 2) ? 16'h42a5 : 16'ha542);
      end
      cmd(32'h9f000000, 1, 3);
      check("identity", rx, 32'ha53c21);
      cmd(32'h5a000010, 5, 2);
      check("param", rx[15:0], 16'hd3d2);
      cmd(32'h38000000, 1);
      check("quad on", quad_mode, 1'b1);
      spi_host_model_inst.frame(32'h05000000, 1, 4, 4, 1, 0, rx);
      check("quad sr1", rx[7:0], 8'h3c);
      spi_host_model_inst.frame(32'hff000000, 1, 4, 4, 0, 0, rx);
      check("quad off", quad_mode, 1'b0);
      @(posedge ref_clk);
      #10 cont_mode_set = 1'b1;
      @(posedge ref_clk);
      #10 cont_mode_set = 1'b0;
      check("cont on", cont_mode, 1'b1);
      cmd(32'hff000000, 1);
      check("cont off", cont_mode, 1'b0);
      stop_test();
   end
endmodule // test_flash_cmd_decoder
bind flash_cmd_decoder flash_cmd_decoder_assertions flash_cmd_decoder_assertions_inst (
   .ref_clk, .nrst, .cs_n, .cont_mode_set, .dq_oe, .quad_mode, .cont_mode, .addr4_mode,
   .ext_addr, .status1, .soft_reset_done);
`default_nettype wire
